//--- pkg/epc_pkg.sv
// constants, field positions and state types of the exception pending
// control block; assumes a 32-bit apb slave port on the processor clock
//
// Behaviour
// R01: deferred-service set bit reads its pending state
// R02: write 1 sets deferred-service pending, 0 ignored
// R03: only that write makes deferred-service pending
// R04: write 1 to bit 27 clears deferred-service
// R05: clear bits 27 and 25 are write-only
// R06: bit 26 reads system-tick pending state
// R07: write 1 sets system-tick pending, 0 ignored
// R08: system-tick clear write clears the set bit
// R09: write 1 to bit 25 clears system-tick
// R10: writing 0 to clear bits changes nothing
// R11: bit 23 shows halt release takes interrupt
// R12: bit 23 reads 0 outside debug mode
// R13: bit 22 reads 1 when any interrupt pends
// R14: pending flag excludes nmi and faults
// R15: reserved bits 24, 21:18 read zero
// R16: software never sets and clears together
// R17: set bits read the live pending state
package epc_pkg;

    // apb address width and data width
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    // number of external interrupt lines feeding the pending flag
    localparam int N_IRQ = 30;
    // number of sticky event bits
    localparam int EV_W = 4;

    // byte offsets of the registers
    localparam logic [11:0] OFF_CTRL = 12'hd04;
    localparam logic [11:0] OFF_EV_STATUS = 12'hd40;
    localparam logic [11:0] OFF_EV_MASK = 12'hd44;

    // field positions of exception_control_state
    localparam int BIT_DS_SET = 28;
    localparam int BIT_DS_CLR = 27;
    localparam int BIT_ST_SET = 26;
    localparam int BIT_ST_CLR = 25;
    localparam int BIT_RSV_HI = 24;
    localparam int BIT_DBG_REL = 23;
    localparam int BIT_ANY_PEND = 22;
    localparam int BIT_RSV_LO_MSB = 21;
    localparam int BIT_RSV_LO_LSB = 18;

    // event bit positions in the status and mask registers
    localparam int EV_DS_SET = 0;
    localparam int EV_ST_SET = 1;
    localparam int EV_DBG_REL = 2;
    localparam int EV_ANY_PEND = 3;

    // reset values
    localparam logic [31:0] RST_RDATA = 32'h0000_0000;
    localparam logic [3:0] RST_EV_STATUS = 4'h0;
    localparam logic [3:0] RST_EV_MASK = 4'h0;
    localparam logic RST_PENDING = 1'b0;

    // apb answer sequencer
    typedef enum logic {
        bus_idle,
        bus_ack
    } epc_bus_t;

    // state of the top module, apart from the pending bits held in epc_pend_bit
    typedef struct packed {
        epc_bus_t bus;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [3:0] ev_status;
        logic [3:0] ev_mask;
        logic irq;
        logic dbg_prev;
        logic any_prev;
    } epc_top_state_t;

    // whole state of one pending bit
    typedef struct packed {
        logic pending;
    } epc_pend_state_t;

    localparam epc_top_state_t TOP_RST = '{
        bus: bus_idle,
        pready: 1'b0,
        pslverr: 1'b0,
        prdata: RST_RDATA,
        ev_status: RST_EV_STATUS,
        ev_mask: RST_EV_MASK,
        irq: 1'b0,
        dbg_prev: 1'b0,
        any_prev: 1'b0
    };

endpackage

//--- verilog/epc_pend_bit.sv
// one exception pending state with software set and clear requests
// assumes requests are single-cycle pulses qualified by the caller
module epc_pend_bit (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic set_req,
    input wire logic clr_req,
    input wire logic taken,
    output logic pending
);

    epc_pkg::epc_pend_state_t cur; // registered state
    epc_pkg::epc_pend_state_t next_cur; // next state

    // set wins over any clear so a new request is never lost
    always_comb
    begin
        next_cur = cur;
        if (set_req)
        begin
            next_cur.pending = 1'b1; // R02 R03 R07 R16
        end
        else if (clr_req || taken)
        begin
            next_cur.pending = 1'b0; // R04 R08 R09 R17
        end
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cur.pending <= epc_pkg::RST_PENDING;
        end
        else if (ce)
        begin
            cur <= next_cur;
        end
    end

    assign pending = cur.pending;

    property p_set_pends;
        @(posedge pclk) disable iff (!presetn)
        (ce && set_req) |=> pending;
    endproperty
    a_set_pends: assert property (p_set_pends) // R02
        else $error("set request did not make the exception pending");

    property p_clr_unpends;
        @(posedge pclk) disable iff (!presetn)
        (ce && clr_req && !set_req) |=> !pending;
    endproperty
    a_clr_unpends: assert property (p_clr_unpends) // R04
        else $error("clear request left the exception pending");

    property p_only_set_path;
        @(posedge pclk) disable iff (!presetn)
        (!pending && !(ce && set_req)) |=> !pending;
    endproperty
    a_only_set_path: assert property (p_only_set_path) // R03
        else $error("exception became pending without a set request");

    property p_hold_quiet;
        @(posedge pclk) disable iff (!presetn)
        (!(ce && (set_req || clr_req || taken))) |=> $stable(pending);
    endproperty
    a_hold_quiet: assert property (p_hold_quiet) // R10
        else $error("pending state moved with no request");

endmodule

//--- verilog/epc_top.sv
// exception pending control register behind an apb slave port
// assumes apb signals synchronous to pclk and a single bus master
//
// Added by the designer: the placing of the registers and the APB slave port.
module epc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave port
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // processor core status
    input wire logic dbg_halted,
    input wire logic dbg_release_irq,
    input wire logic [29:0] irq_lines,
    input wire logic ds_taken,
    input wire logic st_taken,
    // exception requests toward the core
    output logic deferred_service_pending,
    output logic system_tick_pending,
    // summary interrupt of the sticky event bits
    output logic irq
);

    epc_pkg::epc_top_state_t cur; // registered state
    epc_pkg::epc_top_state_t next_cur; // next state

    logic hit_ctrl; // address selects the control register
    logic hit_status; // address selects the event status register
    logic hit_mask; // address selects the event mask register
    logic mapped; // address selects any register
    logic access_done; // transfer completes at this edge
    logic wr_ctrl; // completing write to the control register
    logic ds_set; // deferred-service set request
    logic ds_clr; // deferred-service clear request
    logic st_set; // system-tick set request
    logic st_clr; // system-tick clear request
    logic ds_pend; // live deferred-service pending state
    logic st_pend; // live system-tick pending state
    logic dbg_rel; // debug release indication, gated by debug mode
    logic any_pend; // any interrupt pending
    logic [31:0] ctrl_rd; // read image of the control register
    logic [31:0] rd_mux; // read data selected by address
    logic [3:0] ev; // event pulses of this cycle
    logic ev_clr; // completing read of the event status register
    logic [3:0] ev_keep; // status bits the completing read did not report

    // address decode
    always_comb
    begin
        hit_ctrl = (paddr == epc_pkg::OFF_CTRL);
        hit_status = (paddr == epc_pkg::OFF_EV_STATUS);
        hit_mask = (paddr == epc_pkg::OFF_EV_MASK);
        mapped = hit_ctrl || hit_status || hit_mask;
    end

    // a transfer completes on the edge where the master sees pready
    assign access_done = psel && penable && cur.pready;
    assign wr_ctrl = access_done && pwrite && hit_ctrl;

    // software requests decoded from a completing control write
    always_comb
    begin
        ds_set = wr_ctrl && pwdata[epc_pkg::BIT_DS_SET]; // R02
        ds_clr = wr_ctrl && pwdata[epc_pkg::BIT_DS_CLR]; // R04 R10
        st_set = wr_ctrl && pwdata[epc_pkg::BIT_ST_SET]; // R07
        st_clr = wr_ctrl && pwdata[epc_pkg::BIT_ST_CLR]; // R08 R09 R10
    end

    // deferred-service pending state
    epc_pend_bit u_ds_pend (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .set_req(ds_set),
        .clr_req(ds_clr),
        .taken(ds_taken),
        .pending(ds_pend)
    );

    // system-tick pending state
    epc_pend_bit u_st_pend (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .set_req(st_set),
        .clr_req(st_clr),
        .taken(st_taken),
        .pending(st_pend)
    );

    // core status: debug release only visible while halted
    always_comb
    begin
        dbg_rel = dbg_halted && dbg_release_irq; // R11 R12
        // nmi and faults are not routed here at all
        any_pend = (|irq_lines) || ds_pend || st_pend; // R13 R14
    end

    // read image of the control register
    always_comb
    begin
        ctrl_rd = 32'h0000_0000;
        ctrl_rd[epc_pkg::BIT_DS_SET] = ds_pend; // R01 R17
        ctrl_rd[epc_pkg::BIT_ST_SET] = st_pend; // R06 R17
        // write-only clear bits read as zero
        ctrl_rd[epc_pkg::BIT_DS_CLR] = 1'b0; // R05
        ctrl_rd[epc_pkg::BIT_ST_CLR] = 1'b0; // R05
        ctrl_rd[epc_pkg::BIT_RSV_HI] = 1'b0; // R15
        ctrl_rd[epc_pkg::BIT_DBG_REL] = dbg_rel; // R11 R12
        ctrl_rd[epc_pkg::BIT_ANY_PEND] = any_pend; // R13
        ctrl_rd[epc_pkg::BIT_RSV_LO_MSB:epc_pkg::BIT_RSV_LO_LSB] =
            4'h0; // R15
    end

    // read data multiplexer
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (hit_ctrl)
        begin
            rd_mux = ctrl_rd;
        end
        else if (hit_status)
        begin
            rd_mux[3:0] = cur.ev_status;
        end
        else if (hit_mask)
        begin
            rd_mux[3:0] = cur.ev_mask;
        end
    end

    // event pulses: software sets and rising core indications
    always_comb
    begin
        ev = 4'h0;
        ev[epc_pkg::EV_DS_SET] = ds_set;
        ev[epc_pkg::EV_ST_SET] = st_set;
        ev[epc_pkg::EV_DBG_REL] = dbg_rel && !cur.dbg_prev;
        ev[epc_pkg::EV_ANY_PEND] = any_pend && !cur.any_prev;
        ev_clr = access_done && !pwrite && hit_status;
        ev_keep = cur.ev_status & ~cur.prdata[3:0]; // not yet seen
    end

    // next state: bus answer, sticky events, mask and interrupt
    always_comb
    begin
        next_cur = cur;
        case (cur.bus)
            epc_pkg::bus_idle:
            begin
                // first access cycle: capture the answer
                if (psel && penable)
                begin
                    next_cur.bus = epc_pkg::bus_ack;
                    next_cur.pready = 1'b1;
                    next_cur.pslverr = !mapped;
                    next_cur.prdata = pwrite ? 32'h0000_0000 : rd_mux;
                end
            end
            epc_pkg::bus_ack:
            begin
                // transfer completes at this edge
                next_cur.bus = epc_pkg::bus_idle;
                next_cur.pready = 1'b0;
                next_cur.pslverr = 1'b0;
            end
            default:
            begin
                next_cur.bus = epc_pkg::bus_idle;
                next_cur.pready = 1'b0;
                next_cur.pslverr = 1'b0;
            end
        endcase
        // mask written by software
        if (access_done && pwrite && hit_mask)
        begin
            next_cur.ev_mask = pwdata[3:0];
        end
        // a read clears only the bits it reported: an event that lands
        // between capture and completion survives, as does one this cycle
        next_cur.ev_status = (ev_clr ? ev_keep : cur.ev_status) | ev;
        next_cur.irq = |(next_cur.ev_status & next_cur.ev_mask);
        next_cur.dbg_prev = dbg_rel;
        next_cur.any_prev = any_pend;
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cur <= epc_pkg::TOP_RST;
        end
        else if (ce)
        begin
            cur <= next_cur;
        end
    end

    // outputs straight from flip-flops
    assign prdata = cur.prdata;
    assign pready = cur.pready;
    assign pslverr = cur.pslverr;
    assign irq = cur.irq;
    assign deferred_service_pending = ds_pend;
    assign system_tick_pending = st_pend;

    // helper: completing read of the control register
    logic rd_ctrl_done;
    assign rd_ctrl_done = access_done && !pwrite && hit_ctrl;

    property p_ds_readback;
        @(posedge pclk) disable iff (!presetn)
        (rd_ctrl_done && $past(ce))
            |-> prdata[epc_pkg::BIT_DS_SET] == $past(ds_pend);
    endproperty
    a_ds_readback: assert property (p_ds_readback) // R01
        else $error("deferred-service bit read back wrong state");

    property p_st_readback;
        @(posedge pclk) disable iff (!presetn)
        (rd_ctrl_done && $past(ce))
            |-> prdata[epc_pkg::BIT_ST_SET] == $past(st_pend);
    endproperty
    a_st_readback: assert property (p_st_readback) // R06
        else $error("system-tick bit read back wrong state");

    property p_reserved_zero;
        @(posedge pclk) disable iff (!presetn)
        rd_ctrl_done |-> (prdata[epc_pkg::BIT_RSV_HI] == 1'b0)
            && (prdata[21:18] == 4'h0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) // R15
        else $error("reserved bit read as nonzero");

    property p_dbg_gated;
        @(posedge pclk) disable iff (!presetn)
        (rd_ctrl_done && $past(ce) && !$past(dbg_halted))
            |-> !prdata[epc_pkg::BIT_DBG_REL];
    endproperty
    a_dbg_gated: assert property (p_dbg_gated) // R12
        else $error("debug release bit set outside debug mode");

    property p_any_pend;
        @(posedge pclk) disable iff (!presetn)
        (rd_ctrl_done && $past(ce))
            |-> prdata[epc_pkg::BIT_ANY_PEND] ==
                ($past(|irq_lines) || $past(ds_pend) || $past(st_pend));
    endproperty
    a_any_pend: assert property (p_any_pend) // R13
        else $error("interrupt pending flag disagrees with sources");

    property p_wr_sets_ds;
        @(posedge pclk) disable iff (!presetn)
        (ce && wr_ctrl && pwdata[epc_pkg::BIT_DS_SET])
            |=> deferred_service_pending ##1 1'b1;
    endproperty
    a_wr_sets_ds: assert property (p_wr_sets_ds) // R02
        else $error("deferred-service write did not pend");

    property p_wr_clr_st;
        @(posedge pclk) disable iff (!presetn)
        (ce && wr_ctrl && pwdata[epc_pkg::BIT_ST_CLR]
            && !pwdata[epc_pkg::BIT_ST_SET]) |=> !system_tick_pending;
    endproperty
    a_wr_clr_st: assert property (p_wr_clr_st) // R09
        else $error("system-tick clear write left it pending");

    property p_ready_pulse;
        @(posedge pclk) disable iff (!presetn)
        (pready && ce) |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("pready stayed high after a completed transfer");

    property p_status_rdclr;
        @(posedge pclk) disable iff (!presetn)
        (ce && ev_clr && ev == 4'h0)
            |=> (cur.ev_status & $past(cur.prdata[3:0])) == 4'h0;
    endproperty
    a_status_rdclr: assert property (p_status_rdclr)
        else $error("event status not cleared by its read");

    property p_irq_level;
        @(posedge pclk) disable iff (!presetn)
        (|(cur.ev_status & cur.ev_mask)) |-> irq;
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("unmasked event without interrupt output");

    property p_wr_sets_st;
        @(posedge pclk) disable iff (!presetn)
        (ce && wr_ctrl && pwdata[epc_pkg::BIT_ST_SET])
            |=> system_tick_pending;
    endproperty
    a_wr_sets_st: assert property (p_wr_sets_st) // R07
        else $error("system-tick write did not pend");

    property p_wr_clr_ds;
        @(posedge pclk) disable iff (!presetn)
        (ce && wr_ctrl && pwdata[epc_pkg::BIT_DS_CLR]
            && !pwdata[epc_pkg::BIT_DS_SET]) |=> !deferred_service_pending;
    endproperty
    a_wr_clr_ds: assert property (p_wr_clr_ds) // R04
        else $error("deferred-service clear write left it pending");

    property p_zero_keeps_ds;
        @(posedge pclk) disable iff (!presetn)
        (ce && wr_ctrl && !pwdata[epc_pkg::BIT_DS_SET]
            && !pwdata[epc_pkg::BIT_DS_CLR] && !ds_taken)
            |=> $stable(deferred_service_pending);
    endproperty
    a_zero_keeps_ds: assert property (p_zero_keeps_ds) // R10
        else $error("zero write moved the deferred-service state");

    property p_zero_keeps_st;
        @(posedge pclk) disable iff (!presetn)
        (ce && wr_ctrl && !pwdata[epc_pkg::BIT_ST_SET]
            && !pwdata[epc_pkg::BIT_ST_CLR] && !st_taken)
            |=> $stable(system_tick_pending);
    endproperty
    a_zero_keeps_st: assert property (p_zero_keeps_st) // R10
        else $error("zero write moved the system-tick state");

    property p_dbg_readback;
        @(posedge pclk) disable iff (!presetn)
        (rd_ctrl_done && $past(ce))
            |-> prdata[epc_pkg::BIT_DBG_REL] ==
                ($past(dbg_halted) && $past(dbg_release_irq));
    endproperty
    a_dbg_readback: assert property (p_dbg_readback) // R11
        else $error("debug release bit read back wrong state");

    property p_rdclr_keeps_new;
        @(posedge pclk) disable iff (!presetn)
        (ce && ev_clr) |=> ((cur.ev_status & $past(ev)) == $past(ev));
    endproperty
    a_rdclr_keeps_new: assert property (p_rdclr_keeps_new)
        else $error("event lost in the cycle of a status read");

    property p_rdclr_keeps_unread;
        @(posedge pclk) disable iff (!presetn)
        (ce && ev_clr)
            |=> ((cur.ev_status & $past(ev_keep)) == $past(ev_keep));
    endproperty
    a_rdclr_keeps_unread: assert property (p_rdclr_keeps_unread)
        else $error("status read cleared an event it did not report");

endmodule

//--- testbench/exception_pending_control_tb.sv
// self-checking bench of the exception pending control block over apb
// assumes epc_top with one wait state and the epc_pkg register layout
module exception_pending_control_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // in-scope control fields, clear bits left out as write-only
    localparam logic [31:0] CMP_MASK = 32'h15fc_0000;
    localparam logic [31:0] DS_SET = 32'h0000_0001 << epc_pkg::BIT_DS_SET;
    localparam logic [31:0] DS_CLR = 32'h0000_0001 << epc_pkg::BIT_DS_CLR;
    localparam logic [31:0] ST_SET = 32'h0000_0001 << epc_pkg::BIT_ST_SET;
    localparam logic [31:0] ST_CLR = 32'h0000_0001 << epc_pkg::BIT_ST_CLR;
    // reserved bits 24 and 21:18
    localparam logic [31:0] RSV = 32'h013c_0000;
    // an address with no register behind it
    localparam logic [11:0] OFF_NONE = 12'h100;

    logic pclk = 1'b0; // bus clock
    logic presetn = 1'b0; // active low reset
    logic ce = 1'b1; // clock enable, held on except while the freeze test lowers it
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic dbg_halted = 1'b0; // core status inputs
    logic dbg_release_irq = 1'b0;
    logic [29:0] irq_lines = 30'h0000_0000;
    logic ds_taken = 1'b0;
    logic st_taken = 1'b0;
    logic deferred_service_pending;
    logic system_tick_pending;
    logic irq;
    int mismatches = 0; // failed comparisons
    int cmp_count = 0; // all comparisons

    // 125 mhz clock
    always #4 pclk = ~pclk;

    epc_top i_epc_top (
        .pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .dbg_halted(dbg_halted), .dbg_release_irq(dbg_release_irq),
        .irq_lines(irq_lines), .ds_taken(ds_taken), .st_taken(st_taken),
        .deferred_service_pending(deferred_service_pending),
        .system_tick_pending(system_tick_pending), .irq(irq)
    );

    // prints the counts and the verdict, then stops
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // compares one 32-bit word
    task automatic check_word(input string nm, input logic [31:0] e,
                              input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // compares one flag
    task automatic check_bit(input string nm, input logic e, input logic g);
        cmp_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("Error %s expected %b seen %b", nm, e, g);
        end
    endtask

    // one apb transfer: setup, access until pready at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        int n;
        logic ok;
        n = 0;
        ok = 1'b0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        while (!ok && n < 20)
        begin
            @(posedge pclk);
            n++;
            ok = (pready === 1'b1);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // a transfer that never completes ends the run
        if (!ok)
        begin
            mismatches++;
            $display("Error pready expected 1 seen 0");
            complete_run();
        end
    endtask

    // write that must be accepted
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        check_bit("pslverr", 1'b0, e);
    endtask

    // read that must be accepted
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        logic e;
        apb(1'b0, a, 32'h0000_0000, d, e);
        check_bit("pslverr", 1'b0, e);
    endtask

    // reads control and compares it and the pending outputs
    task automatic chk_ctrl(input logic ds, input logic st, input logic dbg,
                            input logic any);
        logic [31:0] r;
        logic [31:0] e;
        e = 32'h0000_0000;
        e[epc_pkg::BIT_DS_SET] = ds;
        e[epc_pkg::BIT_ST_SET] = st;
        e[epc_pkg::BIT_DBG_REL] = dbg;
        e[epc_pkg::BIT_ANY_PEND] = any;
        rd(epc_pkg::OFF_CTRL, r);
        check_word("ctrl", e, r & CMP_MASK);
        check_bit("ds_pending", ds, deferred_service_pending);
        check_bit("st_pending", st, system_tick_pending);
    endtask

    // main sequence
    initial
    begin
        logic [31:0] r;
        logic e;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        check_bit("irq", 1'b0, irq);
        // reset state and reserved bits
        chk_ctrl(1'b0, 1'b0, 1'b0, 1'b0);
        wr(epc_pkg::OFF_CTRL, RSV);
        chk_ctrl(1'b0, 1'b0, 1'b0, 1'b0);
        // deferred-service set, zero write, clear
        wr(epc_pkg::OFF_CTRL, DS_SET);
        chk_ctrl(1'b1, 1'b0, 1'b0, 1'b1);
        wr(epc_pkg::OFF_CTRL, 32'h0000_0000);
        chk_ctrl(1'b1, 1'b0, 1'b0, 1'b1);
        wr(epc_pkg::OFF_CTRL, DS_CLR);
        chk_ctrl(1'b0, 1'b0, 1'b0, 1'b0);
        // system-tick set, reserved-bit write, clear
        wr(epc_pkg::OFF_CTRL, ST_SET);
        chk_ctrl(1'b0, 1'b1, 1'b0, 1'b1);
        wr(epc_pkg::OFF_CTRL, RSV);
        chk_ctrl(1'b0, 1'b1, 1'b0, 1'b1);
        wr(epc_pkg::OFF_CTRL, ST_CLR);
        chk_ctrl(1'b0, 1'b0, 1'b0, 1'b0);
        // pending cleared by handler entry, read shows live state
        wr(epc_pkg::OFF_CTRL, DS_SET | ST_SET);
        chk_ctrl(1'b1, 1'b1, 1'b0, 1'b1);
        @(posedge pclk);
        ds_taken <= 1'b1;
        @(posedge pclk);
        ds_taken <= 1'b0;
        chk_ctrl(1'b0, 1'b1, 1'b0, 1'b1);
        st_taken <= 1'b1;
        @(posedge pclk);
        st_taken <= 1'b0;
        chk_ctrl(1'b0, 1'b0, 1'b0, 1'b0);
        // debug release flag only in debug mode
        dbg_release_irq <= 1'b1;
        chk_ctrl(1'b0, 1'b0, 1'b0, 1'b0);
        dbg_halted <= 1'b1;
        chk_ctrl(1'b0, 1'b0, 1'b1, 1'b0);
        dbg_release_irq <= 1'b0;
        chk_ctrl(1'b0, 1'b0, 1'b0, 1'b0);
        dbg_halted <= 1'b0;
        // external lines feed the pending flag, never the set bits
        irq_lines <= 30'h0000_0001;
        chk_ctrl(1'b0, 1'b0, 1'b0, 1'b1);
        irq_lines <= 30'h2000_0000;
        chk_ctrl(1'b0, 1'b0, 1'b0, 1'b1);
        irq_lines <= 30'h0000_0000;
        chk_ctrl(1'b0, 1'b0, 1'b0, 1'b0);
        // unmapped address is refused and changes nothing
        apb(1'b1, OFF_NONE, DS_SET, r, e);
        check_bit("pslverr", 1'b1, e);
        apb(1'b0, OFF_NONE, 32'h0000_0000, r, e);
        check_bit("pslverr", 1'b1, e);
        check_word("prdata", 32'h0000_0000, r);
        chk_ctrl(1'b0, 1'b0, 1'b0, 1'b0);
        // events: mask, raise, read-clear
        wr(epc_pkg::OFF_EV_MASK, 32'h0000_0001);
        rd(epc_pkg::OFF_EV_MASK, r);
        check_word("ev_mask", 32'h0000_0001, r);
        rd(epc_pkg::OFF_EV_STATUS, r);
        repeat (2) @(posedge pclk);
        check_bit("irq", 1'b0, irq);
        wr(epc_pkg::OFF_CTRL, ST_SET);
        repeat (2) @(posedge pclk);
        check_bit("irq", 1'b0, irq);
        wr(epc_pkg::OFF_CTRL, DS_SET);
        repeat (2) @(posedge pclk);
        check_bit("irq", 1'b1, irq);
        rd(epc_pkg::OFF_EV_STATUS, r);
        check_word("ev_status", 32'h0000_0003, r & 32'h0000_0003);
        repeat (2) @(posedge pclk);
        check_bit("irq", 1'b0, irq);
        rd(epc_pkg::OFF_EV_STATUS, r);
        check_word("ev_status", 32'h0000_0000, r);
        wr(epc_pkg::OFF_CTRL, DS_CLR | ST_CLR);
        chk_ctrl(1'b0, 1'b0, 1'b0, 1'b0);
        // clock enable low freezes the pending state against handler entry
        wr(epc_pkg::OFF_CTRL, DS_SET);
        ce <= 1'b0;
        ds_taken <= 1'b1;
        repeat (2) @(posedge pclk);
        ds_taken <= 1'b0;
        @(posedge pclk);
        ce <= 1'b1;
        chk_ctrl(1'b1, 1'b0, 1'b0, 1'b1);
        // reset in mid-run drops pending state and the interrupt
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        check_bit("irq", 1'b0, irq);
        presetn <= 1'b1;
        chk_ctrl(1'b0, 1'b0, 1'b0, 1'b0);
        complete_run();
    end
endmodule
